// ---- common/sme_regs.svh ----
// register offsets, field positions, reset values and timing counts of the serial memory controller
// Behaviour
// - An operation that gets no answer from the memory within 30 ms is abandoned and the controller goes idle.
// - A time-out sets the time-out flag at bit 9 of the command register to mark the last operation as failed.
// - A data line held high by a pull-up counts as ready, so a missing memory never causes a time-out then.
// - A command that does not time out drops busy as soon as its serial sequence is finished.
// - Only erase, bulk clear, write and bulk program wait for the memory, so only they can time out.
// - The address-loaded flag at bit 8 is set only after a valid memory was found and the station address loaded.
// - That flag is set after the load at power-up and after a reload, and software clears it by writing a one.
// - The 8-bit address field selects the memory location of read, write and erase; the other commands do not use it.
// - The address field is bits 7 to 0, byte-granular, readable and writable, and resets to zero.
// - Bits 7 to 0 of the data register at B4h hold the byte to write and receive the byte read, reset zero.
`ifndef SME_REGS_SVH
`define SME_REGS_SVH
`define SME_OFF_CMD 8'hB0
`define SME_OFF_DATA 8'hB4
`define SME_OFF_INT_STS 8'hB8
`define SME_OFF_INT_MSK 8'hBC
`define SME_CMD_BUSY_BIT 31
`define SME_CMD_CODE_HI 30
`define SME_CMD_CODE_LO 28
`define SME_CMD_TMO_BIT 9
`define SME_CMD_LOADED_BIT 8
`define SME_INT_DONE_BIT 0
`define SME_INT_TMO_BIT 1
`define SME_INT_LOADED_BIT 2
`define SME_INT_WIDTH 3
`define SME_ADDR_RST 8'h00
`define SME_DATA_RST 8'h00
`define SME_TMO_MS 30
`define SME_SYS_CLK_KHZ 40000
`define SME_TMO_CYCLES (`SME_TMO_MS * `SME_SYS_CLK_KHZ)
`define SME_SCLK_HALF 20
`define SME_SIG_BYTE 8'hA5
`define SME_MAC_BYTES 6
`define SME_OPC_READ 2'h2
`define SME_OPC_WRITE 2'h1
`define SME_OPC_ERASE 2'h3
`define SME_OPC_EXT 2'h0
`define SME_EXT_WR_EN 8'hC0
`define SME_EXT_WR_DIS 8'h00
`define SME_EXT_BULK_PROG 8'h40
`define SME_EXT_BULK_CLR 8'h80
`endif

// ---- common/sme_pkg.sv ----
// types shared by the serial memory controller and its bit sequencer
package sme_pkg;
	typedef enum logic [2:0] {
		SME_CMD_READ = 3'h0,
		SME_CMD_WR_DIS = 3'h1,
		SME_CMD_WR_EN = 3'h2,
		SME_CMD_WRITE = 3'h3,
		SME_CMD_BULK_PROG = 3'h4,
		SME_CMD_ERASE = 3'h5,
		SME_CMD_BULK_CLR = 3'h6,
		SME_CMD_RELOAD = 3'h7
	} sme_cmd_t;
	typedef enum logic [2:0] {
		SME_SEQ_IDLE = 3'h0,
		SME_SEQ_OUT = 3'h1,
		SME_SEQ_IN = 3'h2,
		SME_SEQ_GAP = 3'h3,
		SME_SEQ_POLL = 3'h4,
		SME_SEQ_END = 3'h5
	} sme_seq_st_t;
	typedef enum logic [1:0] {
		SME_CTL_IDLE = 2'h0,
		SME_CTL_RUN = 2'h1,
		SME_CTL_LOAD = 2'h2
	} sme_ctl_st_t;
	typedef struct packed {
		logic [1:0] opc;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic long_frame;
		logic is_read;
		logic wait_ready;
	} sme_frame_t;
endpackage

// ---- common/sme_seq_if.sv ----
// request and answer signals between the controller and its bit sequencer
interface sme_seq_if;
	import sme_pkg::*;
	logic req;
	sme_frame_t frame;
	logic done;
	logic tmo;
	logic [7:0] rdata;
	modport ctl (output req, output frame, input done, input tmo, input rdata);
	modport seq (input req, input frame, output done, output tmo, output rdata);
endinterface

// ---- core/sme_serial.sv ----
// serial bit sequencer: shifts one frame out, reads a byte back or polls for ready
`include "sme_regs.svh"
module sme_serial
	import sme_pkg::*;
#(
	parameter int SCLK_HALF = `SME_SCLK_HALF,
	parameter int TMO_CYC = `SME_TMO_CYCLES
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	sme_seq_if.seq sq,
	output logic mem_cs,
	output logic mem_clk,
	input wire logic mem_io_in,
	output logic mem_io_out,
	output logic mem_io_oe
);
	sme_seq_st_t state, next_state;
	logic [15:0] div, next_div;
	logic [18:0] sh, next_sh;
	logic [4:0] nbits, next_nbits;
	logic [7:0] rd, next_rd;
	logic [20:0] tcnt, next_tcnt;
	logic read_op, next_read_op, wait_op, next_wait_op;
	logic next_cs, next_clk, next_done, next_tmo;
	logic tick;

	// one serial half period per tick
	assign tick = (div == 16'(SCLK_HALF - 1));

	// next-state logic of the sequencer
	always_comb
	begin
		next_state = state;
		next_div = (state == SME_SEQ_IDLE || tick) ? 16'h0000 : div + 16'h0001;
		next_sh = sh;
		next_nbits = nbits;
		next_rd = rd;
		next_tcnt = tcnt;
		next_read_op = read_op;
		next_wait_op = wait_op;
		next_cs = mem_cs;
		next_clk = mem_clk;
		next_done = 1'b0;
		next_tmo = 1'b0;
		case (state)
			SME_SEQ_IDLE:
				if (sq.req)
				begin
					// frame is start bit, opcode, address and optional data byte
					next_sh = {1'b1, sq.frame.opc, sq.frame.addr, sq.frame.wdata};
					next_nbits = sq.frame.long_frame ? 5'h13 : 5'h0B;
					next_read_op = sq.frame.is_read;
					next_wait_op = sq.frame.wait_ready;
					next_cs = 1'b1;
					next_state = SME_SEQ_OUT;
				end
			SME_SEQ_OUT:
				if (tick)
				begin
					next_clk = ~mem_clk;
					if (mem_clk)
					begin
						next_sh = {sh[17:0], 1'b0};
						next_nbits = nbits - 5'h01;
						if (nbits == 5'h01)
						begin
							next_nbits = 5'h08;
							if (read_op)
								next_state = SME_SEQ_IN;
							else if (wait_op)
								next_state = SME_SEQ_GAP;
							else
								next_state = SME_SEQ_END;
						end
					end
				end
			SME_SEQ_IN:
				if (tick)
				begin
					next_clk = ~mem_clk;
					if (!mem_clk)
						next_rd = {rd[6:0], mem_io_in}; // sampled on the rising edge
					else
					begin
						next_nbits = nbits - 5'h01;
						if (nbits == 5'h01)
							next_state = SME_SEQ_END;
					end
				end
			SME_SEQ_GAP:
				if (tick)
				begin
					// the memory only shows its ready state after a select low pulse
					next_cs = ~mem_cs;
					next_tcnt = 21'h000000;
					if (!mem_cs)
						next_state = SME_SEQ_POLL;
				end
			SME_SEQ_POLL:
			begin
				next_tcnt = tcnt + 21'h000001;
				if (mem_io_in)
					next_state = SME_SEQ_END;
				else if (tcnt == 21'(TMO_CYC - 1))
				begin
					next_tmo = 1'b1;
					next_state = SME_SEQ_END;
				end
			end
			SME_SEQ_END:
			begin
				next_cs = 1'b0;
				next_clk = 1'b0;
				next_done = 1'b1;
				next_tmo = sq.tmo;
				next_state = SME_SEQ_IDLE;
			end
			default:
				next_state = SME_SEQ_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state <= SME_SEQ_IDLE;
			div <= 16'h0000;
			sh <= 19'h00000;
			nbits <= 5'h00;
			rd <= 8'h00;
			tcnt <= 21'h000000;
			read_op <= 1'b0;
			wait_op <= 1'b0;
			mem_cs <= 1'b0;
			mem_clk <= 1'b0;
			mem_io_out <= 1'b0;
			mem_io_oe <= 1'b0;
			sq.done <= 1'b0;
			sq.tmo <= 1'b0;
			sq.rdata <= 8'h00;
		end
		else
		begin
			state <= next_state;
			div <= next_div;
			sh <= next_sh;
			nbits <= next_nbits;
			rd <= next_rd;
			tcnt <= next_tcnt;
			read_op <= next_read_op;
			wait_op <= next_wait_op;
			mem_cs <= next_cs;
			mem_clk <= next_clk;
			mem_io_out <= next_sh[18];
			mem_io_oe <= (next_state == SME_SEQ_OUT);
			sq.done <= next_done;
			sq.tmo <= next_tmo;
			sq.rdata <= next_rd;
		end
	end
endmodule // sme_serial

// ---- core/sme_ctrl.sv ----
// serial memory controller: command/status, address, data and interrupt registers
//
// The implementer's own choice: the address-and-strobe port.
`include "sme_regs.svh"
module sme_ctrl
	import sme_pkg::*;
#(
	parameter int SCLK_HALF = `SME_SCLK_HALF,
	parameter int TMO_CYC = `SME_TMO_CYCLES,
	parameter logic [7:0] SIG_BYTE = `SME_SIG_BYTE
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic [47:0] station_addr,
	output logic serial_mem_cs,
	output logic serial_mem_clk,
	input wire logic serial_mem_io_pin_in,
	output logic serial_mem_io_pin_out,
	output logic serial_mem_io_pin_oe
);
	sme_seq_if sq ();

	sme_ctl_st_t state, next_state;
	sme_cmd_t cmd_code, next_cmd_code;
	logic [7:0] addr_field, next_addr_field;
	logic [7:0] data_field, next_data_field;
	logic tmo_flag, next_tmo_flag;
	logic loaded_flag, next_loaded_flag;
	logic [`SME_INT_WIDTH-1:0] int_sts, next_int_sts;
	logic [`SME_INT_WIDTH-1:0] int_msk, next_int_msk;
	logic [31:0] next_reg_rdata;
	logic next_irq;
	logic [47:0] next_station_addr;
	logic [2:0] ld_idx, next_ld_idx;
	logic boot_pend, next_boot_pend;
	logic req, next_req;
	sme_frame_t frame, next_frame;
	logic busy;
	logic wr_cmd, wr_data, wr_sts, wr_msk;
	logic [`SME_INT_WIDTH-1:0] int_set;
	logic clr_tmo, clr_loaded;

	// builds the serial frame for a command and a location
	function automatic sme_frame_t build_frame(input sme_cmd_t code, input logic [7:0] loc, input logic [7:0] wd);
		sme_frame_t f;
		f.opc = `SME_OPC_READ;
		f.addr = loc;
		f.wdata = wd;
		f.long_frame = 1'b0;
		f.is_read = 1'b0;
		f.wait_ready = 1'b0;
		case (code)
			SME_CMD_READ, SME_CMD_RELOAD:
				f.is_read = 1'b1;
			SME_CMD_WR_DIS:
			begin
				f.opc = `SME_OPC_EXT;
				f.addr = `SME_EXT_WR_DIS;
			end
			SME_CMD_WR_EN:
			begin
				f.opc = `SME_OPC_EXT;
				f.addr = `SME_EXT_WR_EN;
			end
			SME_CMD_WRITE:
			begin
				f.opc = `SME_OPC_WRITE;
				f.long_frame = 1'b1;
				f.wait_ready = 1'b1;
			end
			SME_CMD_BULK_PROG:
			begin
				f.opc = `SME_OPC_EXT;
				f.addr = `SME_EXT_BULK_PROG;
				f.long_frame = 1'b1;
				f.wait_ready = 1'b1;
			end
			SME_CMD_ERASE:
			begin
				f.opc = `SME_OPC_ERASE;
				f.wait_ready = 1'b1;
			end
			SME_CMD_BULK_CLR:
			begin
				f.opc = `SME_OPC_EXT;
				f.addr = `SME_EXT_BULK_CLR;
				f.wait_ready = 1'b1;
			end
			default:
				f.is_read = 1'b1;
		endcase
		return f;
	endfunction

	// busy covers every state but idle, so it falls with done or time-out alike
	assign busy = (state != SME_CTL_IDLE);

	// register address decode
	always_comb
	begin
		wr_cmd = 1'b0;
		wr_data = 1'b0;
		wr_sts = 1'b0;
		wr_msk = 1'b0;
		// exact offsets only; any other address is ignored
		if (reg_wr && reg_addr == `SME_OFF_CMD)
			wr_cmd = 1'b1;
		else if (reg_wr && reg_addr == `SME_OFF_DATA)
			wr_data = 1'b1;
		else if (reg_wr && reg_addr == `SME_OFF_INT_STS)
			wr_sts = 1'b1;
		else if (reg_wr && reg_addr == `SME_OFF_INT_MSK)
			wr_msk = 1'b1;
	end

	// write-one-to-clear strobes for the sticky command flags
	assign clr_tmo = wr_cmd && reg_wdata[`SME_CMD_TMO_BIT];
	assign clr_loaded = wr_cmd && reg_wdata[`SME_CMD_LOADED_BIT];

	// read data, present only in the cycle after the strobe
	always_comb
	begin
		next_reg_rdata = 32'h00000000;
		if (reg_rd && reg_addr == `SME_OFF_CMD)
		begin
			next_reg_rdata[`SME_CMD_BUSY_BIT] = busy;
			next_reg_rdata[`SME_CMD_CODE_HI:`SME_CMD_CODE_LO] = cmd_code;
			next_reg_rdata[`SME_CMD_TMO_BIT] = tmo_flag;
			next_reg_rdata[`SME_CMD_LOADED_BIT] = loaded_flag;
			next_reg_rdata[7:0] = addr_field;
		end
		else if (reg_rd && reg_addr == `SME_OFF_DATA)
			next_reg_rdata[7:0] = data_field; // upper bits reserved, read zero
		else if (reg_rd && reg_addr == `SME_OFF_INT_STS)
			next_reg_rdata[`SME_INT_WIDTH-1:0] = int_sts;
		else if (reg_rd && reg_addr == `SME_OFF_INT_MSK)
			next_reg_rdata[`SME_INT_WIDTH-1:0] = int_msk;
	end

	// command flow: single commands, and the station address load at boot or on reload
	always_comb
	begin
		next_state = state;
		next_cmd_code = cmd_code;
		next_addr_field = addr_field;
		next_data_field = data_field;
		next_station_addr = station_addr;
		next_ld_idx = ld_idx;
		next_boot_pend = boot_pend;
		next_req = 1'b0;
		next_frame = frame;
		int_set = '0;
		next_tmo_flag = tmo_flag & ~clr_tmo;
		next_loaded_flag = loaded_flag & ~clr_loaded;
		// fields cannot move under a running operation
		if (wr_data && !busy)
			next_data_field = reg_wdata[7:0];
		if (wr_cmd && !busy)
			next_addr_field = reg_wdata[7:0];
		case (state)
			SME_CTL_IDLE:
				if (boot_pend || (wr_cmd && reg_wdata[`SME_CMD_BUSY_BIT]))
				begin
					// a pending boot load goes before any host start
					if (boot_pend)
						next_cmd_code = SME_CMD_RELOAD;
					else
						next_cmd_code = sme_cmd_t'(reg_wdata[`SME_CMD_CODE_HI:`SME_CMD_CODE_LO]);
					next_boot_pend = 1'b0;
					next_req = 1'b1;
					if (next_cmd_code == SME_CMD_RELOAD)
					begin
						next_ld_idx = 3'h0;
						next_frame = build_frame(SME_CMD_READ, 8'h00, 8'h00);
						next_state = SME_CTL_LOAD;
					end
					else
					begin
						// location comes from the address field just written
						next_frame = build_frame(next_cmd_code, next_addr_field, data_field);
						next_state = SME_CTL_RUN;
					end
				end
			SME_CTL_RUN:
				if (sq.done)
				begin
					int_set[`SME_INT_DONE_BIT] = 1'b1;
					// a time-out leaves the data register as it was
					if (sq.tmo)
					begin
						next_tmo_flag = 1'b1;
						int_set[`SME_INT_TMO_BIT] = 1'b1;
					end
					else if (frame.is_read)
						next_data_field = sq.rdata;
					next_state = SME_CTL_IDLE;
				end
			SME_CTL_LOAD:
				if (sq.done)
				begin
					// location 0 holds the signature, not a station byte
					if (ld_idx != 3'h0)
						next_station_addr[8 * (32'(ld_idx) - 1) +: 8] = sq.rdata;
					// a blank or absent memory fails the signature and does not set the flag
					if ((ld_idx == 3'h0 && sq.rdata != SIG_BYTE) || sq.tmo)
					begin
						int_set[`SME_INT_DONE_BIT] = 1'b1;
						next_state = SME_CTL_IDLE;
					end
					else if (ld_idx == 3'(`SME_MAC_BYTES))
					begin
						next_loaded_flag = 1'b1;
						int_set[`SME_INT_DONE_BIT] = 1'b1;
						int_set[`SME_INT_LOADED_BIT] = 1'b1;
						next_state = SME_CTL_IDLE;
					end
					else
					begin
						next_ld_idx = ld_idx + 3'h1;
						next_frame = build_frame(SME_CMD_READ, {5'h00, next_ld_idx}, 8'h00);
						next_req = 1'b1;
					end
				end
			default:
				next_state = SME_CTL_IDLE;
		endcase
		// an event in the same cycle as its clear wins
		if (int_set[`SME_INT_TMO_BIT])
			next_tmo_flag = 1'b1;
	end

	// interrupt status, mask and level output
	always_comb
	begin
		next_int_sts = (int_sts & ~(wr_sts ? reg_wdata[`SME_INT_WIDTH-1:0] : '0)) | int_set;
		next_int_msk = wr_msk ? reg_wdata[`SME_INT_WIDTH-1:0] : int_msk;
		next_irq = |(next_int_sts & next_int_msk);
	end

	// controller registers
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state <= SME_CTL_IDLE;
			cmd_code <= SME_CMD_READ;
			addr_field <= `SME_ADDR_RST;
			data_field <= `SME_DATA_RST;
			tmo_flag <= 1'b0;
			loaded_flag <= 1'b0;
			int_sts <= '0;
			int_msk <= '0;
			reg_rdata <= 32'h00000000;
			irq <= 1'b0;
			station_addr <= 48'h000000000000;
			ld_idx <= 3'h0;
			boot_pend <= 1'b1; // station address load after power-up
			req <= 1'b0;
			frame <= '0;
		end
		else
		begin
			state <= next_state;
			cmd_code <= next_cmd_code;
			addr_field <= next_addr_field;
			data_field <= next_data_field;
			tmo_flag <= next_tmo_flag;
			loaded_flag <= next_loaded_flag;
			int_sts <= next_int_sts;
			int_msk <= next_int_msk;
			reg_rdata <= next_reg_rdata;
			irq <= next_irq;
			station_addr <= next_station_addr;
			ld_idx <= next_ld_idx;
			boot_pend <= next_boot_pend;
			req <= next_req;
			frame <= next_frame;
		end
	end

	// request and frame reach the sequencer over the interface
	assign sq.req = req;
	assign sq.frame = frame;

	// serial bit engine with the no-response timer
	sme_serial #(
		.SCLK_HALF(SCLK_HALF),
		.TMO_CYC(TMO_CYC)
	) u_serial (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.sq(sq),
		.mem_cs(serial_mem_cs),
		.mem_clk(serial_mem_clk),
		.mem_io_in(serial_mem_io_pin_in),
		.mem_io_out(serial_mem_io_pin_out),
		.mem_io_oe(serial_mem_io_pin_oe)
	);
endmodule // sme_ctrl

// ---- bench/sme_mem_model.sv ----
// behavioural serial memory chip sitting on the far side of the controller
module sme_mem_model
(
	input wire logic sys_clk,
	input wire logic cs,
	input wire logic sclk,
	input wire logic din,
	input wire logic fitted,
	input wire logic pull_hi,
	output logic dout
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [256];
	logic [18:0] sh = 19'h0;
	logic [7:0] q = 8'h00;
	logic [1:0] op;
	logic [7:0] ad;
	logic wen = 1'b0;
	logic rdo = 1'b0;
	logic rbit = 1'b0;
	int n = 0;
	int busy = 0;
	// signature at location 0, station bytes 11h..16h after it
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h10 + i[7:0];
		mem[0] = 8'hA5;
	end
	assign op = (n == 19) ? sh[17:16] : sh[9:8];
	assign ad = (n == 19) ? sh[15:8] : sh[7:0];
	// shift in on rising serial clock; a read loads its byte after the address
	always @(posedge sclk)
		if (cs)
		begin
			sh <= {sh[17:0], din};
			n <= n + 1;
			if (n == 10 && sh[8:7] == 2'h2)
			begin
				q <= mem[{sh[6:0], din}];
				rdo <= 1'b1;
			end
		end
	// read bits change on the falling edge so they are settled at the sampling edge
	always @(negedge sclk)
		if (cs && rdo)
		begin
			rbit <= q[7];
			q <= {q[6:0], 1'b0};
		end
	// frame takes effect when select drops; programming keeps the chip busy a while
	always @(posedge cs or negedge cs)
		if (cs)
		begin
			n <= 0;
			rdo <= 1'b0;
		end
		else if (fitted)
		begin
			if (op == 2'h0 && ad[7:6] == 2'h3)
				wen = 1'b1;
			if (op == 2'h0 && ad[7:6] == 2'h0)
				wen = 1'b0;
			if (wen && op != 2'h2)
				busy <= 30;
			if (wen && op == 2'h1)
				mem[ad] = sh[7:0];
			for (int i = 0; i < 256; i++)
				if (wen && ((op == 2'h0 && (ad == 8'h40 || ad == 8'h80)) || (op == 2'h3 && i == ad)))
					mem[i] = (op == 2'h0 && ad == 8'h40) ? sh[7:0] : 8'hFF;
		end
	always @(posedge sys_clk)
		if (busy > 0)
			busy <= busy - 1;
	// released line falls to its pull level; ready shows as high while polled
	assign dout = !fitted ? pull_hi : (cs && rdo) ? rbit : (cs && n == 0) ? (busy == 0) : pull_hi;
endmodule // sme_mem_model

// ---- bench/sme_ctrl_asserts.sv ----
// port-level timing checks of the serial memory controller
`include "sme_regs.svh"
module sme_ctrl_asserts
#(
	parameter int SCLK_HALF = `SME_SCLK_HALF,
	parameter int TMO_CYC = `SME_TMO_CYCLES
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic serial_mem_cs,
	input wire logic serial_mem_clk,
	input wire logic serial_mem_io_pin_in,
	input wire logic serial_mem_io_pin_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	int low_cnt;
	// length of the quiet poll: select up, clock low, line released
	always_ff @(posedge sys_clk)
		if (!reset_n || !serial_mem_cs || serial_mem_clk || serial_mem_io_pin_oe)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside the answer cycle");
	a_data_upper: assert property ($past(reg_rd && reg_addr == `SME_OFF_DATA) |-> reg_rdata[31:8] == 24'h0)
		else $error("data register upper bits not zero");
	a_unmapped_zero: assert property ($past(reg_rd && !(reg_addr inside {`SME_OFF_CMD, `SME_OFF_DATA,
		`SME_OFF_INT_STS, `SME_OFF_INT_MSK})) |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_clk_idle: assert property (!serial_mem_cs |-> !serial_mem_clk)
		else $error("serial clock moves without select");
	a_oe_in_frame: assert property (serial_mem_io_pin_oe |-> serial_mem_cs)
		else $error("data line driven outside a frame");
	a_clk_high_hold: assert property ($rose(serial_mem_clk) |=> serial_mem_clk)
		else $error("serial clock high phase too short");
	a_tmo_bound: assert property (low_cnt <= TMO_CYC + 8)
		else $error("poll runs past the time-out");
	a_ready_ends: assert property ((low_cnt > 2 * SCLK_HALF + 2 && serial_mem_io_pin_in) |-> ##[1:6] !serial_mem_cs)
		else $error("ready line did not end the poll");
endmodule // sme_ctrl_asserts
bind sme_ctrl sme_ctrl_asserts #(.SCLK_HALF(SCLK_HALF), .TMO_CYC(TMO_CYC)) u_chk (.sys_clk(sys_clk),
	.reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_mem_cs(serial_mem_cs),
	.serial_mem_clk(serial_mem_clk), .serial_mem_io_pin_in(serial_mem_io_pin_in),
	.serial_mem_io_pin_oe(serial_mem_io_pin_oe));

// ---- bench/tb_sme_ctrl.sv ----
// self-checking bench for the serial memory controller
`include "sme_regs.svh"
module tb_sme_ctrl
	import sme_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TMO = 200;
	logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	logic [47:0] station_addr;
	logic irq, cs, sclk, io_out, io_oe, io_mem, io_in, fitted = 1'b1, pull_hi = 1'b0;
	int err_total = 0, total_checks = 0, polls;
	sme_cmd_t tc [8] = '{SME_CMD_WRITE, SME_CMD_BULK_PROG, SME_CMD_ERASE, SME_CMD_BULK_CLR,
		SME_CMD_READ, SME_CMD_WR_DIS, SME_CMD_WR_EN, SME_CMD_RELOAD};
	// shared line: the block wins while it drives
	assign io_in = io_oe ? io_out : io_mem;
	always #12.5 sys_clk = ~sys_clk;
	sme_ctrl #(.SCLK_HALF(2), .TMO_CYC(TMO)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.station_addr(station_addr), .serial_mem_cs(cs), .serial_mem_clk(sclk), .serial_mem_io_pin_in(io_in),
		.serial_mem_io_pin_out(io_out), .serial_mem_io_pin_oe(io_oe));
	sme_mem_model u_mem (.sys_clk(sys_clk), .cs(cs), .sclk(sclk), .din(io_in), .fitted(fitted),
		.pull_hi(pull_hi), .dout(io_mem));
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// answer is looked at inside its single cycle
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// bounded poll of busy; polls tells how long the command took
	task automatic idle();
		polls = 0;
		d = 32'hFFFFFFFF;
		while (d[31] !== 1'b0 && polls < 500)
		begin
			rd(`SME_OFF_CMD);
			polls++;
		end
		chk(d[31], 1'b0);
	endtask
	task automatic cmd(input sme_cmd_t c, input logic [7:0] a);
		wr(`SME_OFF_CMD, {1'b1, c, 20'h0, a});
		rd(`SME_OFF_CMD);
		chk(d[31], 1'b1);
		idle();
	endtask
	task automatic t_boot();
		repeat (3) @(posedge sys_clk);
		idle();
		chk(station_addr, 48'h161514131211);
		rd(`SME_OFF_INT_STS);
		chk(d, 32'h5);
		wr(`SME_OFF_INT_STS, 32'h7);
		rd(`SME_OFF_INT_STS);
		chk(d, 32'h0);
		rd(`SME_OFF_CMD);
		chk(d[9:8], 2'b01);
		wr(`SME_OFF_CMD, 32'h100);
		rd(`SME_OFF_CMD);
		chk(d[8], 1'b0);
		cmd(SME_CMD_RELOAD, 8'h00);
		rd(`SME_OFF_CMD);
		chk(d[9:8], 2'b01);
		rd(`SME_OFF_INT_STS);
		chk(d, 32'h5);
		$display("test boot done");
	endtask
	task automatic t_regs();
		wr(`SME_OFF_CMD, 32'h5A);
		rd(`SME_OFF_CMD);
		chk(d[7:0], 8'h5A);
		wr(`SME_OFF_DATA, 32'hFFFFFF3C);
		rd(`SME_OFF_DATA);
		chk(d, 32'h3C);
		rd(8'hC4);
		chk(d, 32'h0);
		$display("test regs done");
	endtask
	// program, read of a neighbouring location, erase and both bulk operations on a fitted chip
	task automatic t_rw();
		cmd(SME_CMD_WR_EN, 8'h00);
		wr(`SME_OFF_DATA, 32'h96);
		cmd(SME_CMD_WRITE, 8'h20);
		chk(u_mem.mem[8'h20], 8'h96);
		rd(`SME_OFF_CMD);
		chk(d[9], 1'b0);
		cmd(SME_CMD_READ, 8'h21);
		rd(`SME_OFF_DATA);
		chk(d, 32'h31);
		cmd(SME_CMD_ERASE, 8'h20);
		chk(u_mem.mem[8'h20], 8'hFF);
		wr(`SME_OFF_DATA, 32'h5E);
		cmd(SME_CMD_BULK_PROG, 8'h00);
		chk(u_mem.mem[8'hC3], 8'h5E);
		cmd(SME_CMD_BULK_CLR, 8'h00);
		chk(u_mem.mem[8'hC3], 8'hFF);
		$display("test rw done");
	endtask
	// no chip and a low line: only the four programming commands time out
	task automatic t_tmo();
		fitted = 1'b0;
		// the reload earlier left the loaded flag set; a failed load must not set it again
		wr(`SME_OFF_CMD, 32'h100);
		wr(`SME_OFF_INT_MSK, 32'h2);
		rd(`SME_OFF_INT_MSK);
		chk(d, 32'h2);
		for (int i = 0; i < 8; i++)
		begin
			cmd(tc[i], 8'h01);
			rd(`SME_OFF_CMD);
			chk(d[9:8], {i < 4, 1'b0});
			chk(irq, i < 4);
			wr(`SME_OFF_INT_STS, 32'h2);
			wr(`SME_OFF_CMD, 32'h200);
		end
		rd(`SME_OFF_CMD);
		chk(d[9], 1'b0);
		$display("test timeout done");
	endtask
	// no chip but a pulled-up line: ends at once without the time-out
	task automatic t_pull();
		pull_hi = 1'b1;
		cmd(SME_CMD_WRITE, 8'h02);
		chk(polls < 100, 1'b1);
		rd(`SME_OFF_CMD);
		chk(d[9], 1'b0);
		$display("test pullup done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_boot();
		t_regs();
		t_rw();
		t_tmo();
		t_pull();
		complete_run();
	end
	// a hang is cut short well past the expected run length
	initial
	begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		complete_run();
	end
endmodule // tb_sme_ctrl
